// ===== logic/fff_buf.sv
`timescale 1ns/1ps
module fff_buf
    import fff_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
)(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_shape
        $error("fff_buf: depth must be a power of two and width positive");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic push;
    logic pop;

    assign in_ready_o = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_q != rp_q;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
endmodule // fff_buf

// ===== logic/fff_cfg.svh
`ifndef FFF_CFG_SVH
`define FFF_CFG_SVH
`define FFF_PTR_W 12
`define FFF_THR_W 12
`define FFF_SPACE_BITS 13'h1000
`define FFF_PTR_RST 12'h000
`define FFF_BUF_DEPTH 8
`define FFF_LEVEL_RST 13'h0000
`define FFF_RD_BIT_RST 1'b0
`define FFF_FULL_RST 1'b0
`define FFF_EMPTY_RST 1'b1
`define FFF_AF_RST 1'b0
`define FFF_AE_RST 1'b1
`define FFF_AF_THR_RST 12'hfff
`define FFF_AE_THR_RST 12'h000
`endif

// ===== logic/fff_fifo.sv
`timescale 1ns/1ps
`include "fff_cfg.svh"
// What this block does
// - Thresholds arrive as twelve-bit user inputs.
// - Separate write and read pointers count data bits moved.
// - Almost-full when difference reaches full threshold.
// - Almost-empty when difference at most empty threshold.
// - Thresholds and pointers count data bits.
// - Almost-full holds until difference drops below.
// - Almost-empty holds until difference rises above.
// - Full threshold in write entries, empty in read.
// - User scales nine/eighteen-bit counts by eight/sixteen.
// - Full/empty when whole word cannot move.
// - Full stays while freed space below write word.
module fff_fifo
    import fff_pkg::*;
#(
    parameter int WR_W = 4,
    parameter int RD_W = 2
)(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    fff_link_if.dev lnk
);
    localparam int MEM_BITS = 1 << `FFF_PTR_W;

    // Write widths above 16 would overrun the 16-bit write staging; widths not dividing the storage would split words across the wrap.
    if (WR_W < 1 || RD_W < 1 || WR_W > 16 || RD_W > 16)
    begin : g_bad_range
        $error("fff_fifo: port widths must lie between 1 and 16");
    end

    if ((MEM_BITS % WR_W) != 0 || (MEM_BITS % RD_W) != 0)
    begin : g_bad_split
        $error("fff_fifo: port widths must divide the storage");
    end

    logic mem_q [MEM_BITS];
    fff_ptr_t write_pointer_q;
    fff_ptr_t write_pointer_d;
    fff_ptr_t read_pointer_q;
    fff_ptr_t read_pointer_d;
    fff_ptr_t wr_step;
    fff_ptr_t rd_step;
    fff_ptr_t diff_d;
    logic [12:0] level_q;
    logic [12:0] level_d;
    logic [12:0] wr_w13;
    logic [12:0] rd_w13;
    logic [15:0] wr_data16;
    logic [RD_W-1:0] rd_data_q;
    logic full_q;
    logic full_d;
    logic empty_q;
    logic empty_d;
    logic af_q;
    logic af_d;
    logic ae_q;
    logic ae_d;
    logic do_wr;
    logic do_rd;

    assign wr_step = 12'(WR_W);
    assign rd_step = 12'(RD_W);
    assign wr_w13 = 13'(WR_W);
    assign rd_w13 = 13'(RD_W);
    assign wr_data16 = 16'(lnk.wr_data);

    // A word moves only when it fits whole, so a refused request changes nothing.
    assign do_wr = lnk.wr_valid && !full_q;
    assign do_rd = lnk.rd_ready && !empty_q;
    assign lnk.wr_ready = !full_q;
    assign lnk.rd_valid = !empty_q;
    assign lnk.rd_data = rd_data_q;
    assign lnk.full = full_q;
    assign lnk.empty = empty_q;
    assign lnk.almost_full_flag = af_q;
    assign lnk.almost_empty_flag = ae_q;

    // Pointers advance by the port width in bits.
    always_comb
    begin
        write_pointer_d = write_pointer_q;
        read_pointer_d = read_pointer_q;
        if (do_wr)
            write_pointer_d = write_pointer_q + wr_step;
        if (do_rd)
            read_pointer_d = read_pointer_q + rd_step;
    end

    // The pointer difference wraps at 4096, so the level keeps a thirteenth bit.
    always_comb
    begin
        level_d = level_q;
        if (do_wr)
            level_d = level_d + wr_w13;
        if (do_rd)
            level_d = level_d - rd_w13;
    end

    // The difference is taken from the pointers after this edge's moves.
    assign diff_d = write_pointer_d - read_pointer_d;

    // Each pointer wraps at the top of the bit space by plain overflow.
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            write_pointer_q <= `FFF_PTR_RST;
        else
            write_pointer_q <= write_pointer_d;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            read_pointer_q <= `FFF_PTR_RST;
        else
            read_pointer_q <= read_pointer_d;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            level_q <= `FFF_LEVEL_RST;
        else
            level_q <= level_d;
    end

    // Storage is bit-addressed so mixed widths share one pointer space.
    // Each cell decides for itself whether the current write covers it.
    for (genvar a = 0; a < MEM_BITS; a++)
    begin : g_cell
        fff_ptr_t lane;

        assign lane = fff_ptr_t'(a) - write_pointer_q;

        always_ff @(posedge clk_sys_i)
        begin
            if (do_wr && lane < wr_step)
                mem_q[a] <= wr_data16[lane[3:0]];
        end
    end

    // Read data is registered and stands until the next read.
    for (genvar b = 0; b < RD_W; b++)
    begin : g_rd_bit
        fff_ptr_t addr;

        assign addr = read_pointer_q + fff_ptr_t'(b);

        always_ff @(posedge clk_sys_i)
        begin
            if (reset_i)
                rd_data_q[b] <= `FFF_RD_BIT_RST;
            else if (do_rd)
                rd_data_q[b] <= mem_q[addr];
        end
    end

    // Flags follow whole-word room, not raw bit counts.
    always_comb
    begin
        full_d = (`FFF_SPACE_BITS - level_d) < wr_w13;
        empty_d = level_d < rd_w13;
    end

    // Thresholds are compared as bit counts after each update.
    always_comb
    begin
        // A full buffer of 4096 bits still counts as at or above any threshold.
        af_d = level_d[12] || (diff_d >= lnk.almost_full_threshold);
        ae_d = !level_d[12] && (diff_d <= lnk.almost_empty_threshold);
    end

    // Registered flags keep glitches of the adders off the outputs.
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            full_q <= `FFF_FULL_RST;
        else
            full_q <= full_d;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            empty_q <= `FFF_EMPTY_RST;
        else
            empty_q <= empty_d;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            af_q <= `FFF_AF_RST;
        else
            af_q <= af_d;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            ae_q <= `FFF_AE_RST;
        else
            ae_q <= ae_d;
    end
endmodule // fff_fifo

// ===== logic/fff_link_if.sv
`timescale 1ns/1ps
interface fff_link_if #(
    parameter int WR_W = 4,
    parameter int RD_W = 2
);
    logic wr_valid;
    logic wr_ready;
    logic [WR_W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [RD_W-1:0] rd_data;
    logic [11:0] almost_full_threshold;
    logic [11:0] almost_empty_threshold;
    logic full;
    logic empty;
    logic almost_full_flag;
    logic almost_empty_flag;
    modport dev (
        input wr_valid, wr_data, rd_ready, almost_full_threshold, almost_empty_threshold,
        output wr_ready, rd_valid, rd_data, full, empty, almost_full_flag, almost_empty_flag
    );
    modport usr (
        output wr_valid, wr_data, rd_ready, almost_full_threshold, almost_empty_threshold,
        input wr_ready, rd_valid, rd_data, full, empty, almost_full_flag, almost_empty_flag
    );
endinterface

// ===== logic/fff_pkg.sv
package fff_pkg;
    typedef logic [11:0] fff_ptr_t;
    typedef logic [11:0] fff_thr_t;
    typedef enum logic [1:0] {
        FFF_W1,
        FFF_W2,
        FFF_W4,
        FFF_W8
    } fff_width_e;
endpackage

// ===== logic/fff_user.sv
`timescale 1ns/1ps
`include "fff_cfg.svh"
// User end: stages source words in a small buffer and drains read words.
module fff_user
    import fff_pkg::*;
#(
    parameter int WR_W = 4,
    parameter int RD_W = 2
)(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic src_valid_i,
    output logic src_ready_o,
    input wire logic [WR_W-1:0] src_data_i,
    input wire logic [11:0] af_words_i,
    input wire logic [11:0] ae_words_i,
    output logic snk_valid_o,
    input wire logic snk_ready_i,
    output logic [RD_W-1:0] snk_data_o,
    output logic full_o,
    output logic empty_o,
    output logic almost_full_o,
    output logic almost_empty_o,
    fff_link_if.usr lnk
);
    logic buf_valid;
    logic [WR_W-1:0] buf_data;
    logic [11:0] af_q;
    logic [11:0] ae_q;

    fff_buf #(.WIDTH(WR_W), .DEPTH(`FFF_BUF_DEPTH)) u_buf (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_valid_i(src_valid_i),
        .in_ready_o(src_ready_o),
        .in_data_i(src_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(lnk.wr_ready),
        .out_data_o(buf_data)
    );

    // Word counts become bit counts; nine and eighteen scale as eight and sixteen.
    function automatic logic [11:0] fff_scale(input logic [11:0] words, input int w);
        int s;
        s = (w == 9) ? 8 : (w == 18) ? 16 : w;
        return 12'(words * s);
    endfunction

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            af_q <= `FFF_AF_THR_RST;
            ae_q <= `FFF_AE_THR_RST;
        end
        else
        begin
            af_q <= fff_scale(af_words_i, WR_W);
            ae_q <= fff_scale(ae_words_i, RD_W);
        end
    end

    assign lnk.almost_full_threshold = af_q;
    assign lnk.almost_empty_threshold = ae_q;
    assign lnk.wr_valid = buf_valid;
    assign lnk.wr_data = buf_data;
    assign lnk.rd_ready = snk_ready_i;
    assign snk_valid_o = lnk.rd_valid;
    assign snk_data_o = lnk.rd_data;
    assign full_o = lnk.full;
    assign empty_o = lnk.empty;
    assign almost_full_o = lnk.almost_full_flag;
    assign almost_empty_o = lnk.almost_empty_flag;
endmodule // fff_user

// ===== tb/fff_link_monitor.sv
`timescale 1ns/1ps
module fff_link_monitor #(
    parameter int WR_W = 4,
    parameter int RD_W = 2
)(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [RD_W-1:0] rd_data,
    input wire logic [11:0] almost_full_threshold,
    input wire logic [11:0] almost_empty_threshold,
    input wire logic full,
    input wire logic empty,
    input wire logic almost_full_flag,
    input wire logic almost_empty_flag
);
    logic [12:0] lvl_q;
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            lvl_q <= 13'h0;
        else
            lvl_q <= lvl_q + ((wr_valid && wr_ready) ? 13'(WR_W) : 13'h0)
                - ((rd_valid && rd_ready) ? 13'(RD_W) : 13'h0);
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    property p_full;
        full == (lvl_q > 13'(4096 - WR_W));
    endproperty
    a_full: assert property (p_full) else $error("full wrong");
    property p_empty;
        empty == (lvl_q < 13'(RD_W));
    endproperty
    a_empty: assert property (p_empty) else $error("empty wrong");
    property p_af;
        almost_full_flag == (lvl_q >= {1'b0, $past(almost_full_threshold)});
    endproperty
    a_af: assert property (p_af) else $error("almost full wrong");
    property p_ae;
        almost_empty_flag == (lvl_q <= {1'b0, $past(almost_empty_threshold)});
    endproperty
    a_ae: assert property (p_ae) else $error("almost empty wrong");
    property p_wrdy;
        wr_ready == (lvl_q <= 13'(4096 - WR_W));
    endproperty
    a_wrdy: assert property (p_wrdy) else $error("write taken when full");
    property p_rvld;
        rd_valid == (lvl_q >= 13'(RD_W));
    endproperty
    a_rvld: assert property (p_rvld) else $error("read offered when empty");
    property p_rdata;
        !$past(rd_valid && rd_ready) |-> $stable(rd_data);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    property p_ahold;
        almost_full_flag && !(rd_valid && rd_ready) && $stable(almost_full_threshold)
            |=> almost_full_flag;
    endproperty
    a_ahold: assert property (p_ahold) else $error("almost full dropped");
endmodule // fff_link_monitor

// ===== tb/fifo_flag_logic_test.sv
`timescale 1ns/1ps
module fifo_flag_logic_test;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic src_valid = 1'b0;
    logic [3:0] src_data = 4'h0;
    logic snk_ready = 1'b0;
    logic src_ready, snk_valid, full, empty, a_full, a_empty;
    logic [1:0] snk_data;
    logic [7:0] rows [5] = '{8'hbe, 8'h69, 8'h00, 8'hff, 8'h96};
    logic [1:0] tail [5] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h0};
    logic [11:0] af_words = 12'h003;
    logic [11:0] ae_words = 12'h002;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    fff_link_if #(.WR_W(4), .RD_W(2)) lnk ();
    fff_fifo i_fff_fifo (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .lnk(lnk));
    fff_user i_fff_user (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .src_valid_i(src_valid),
        .src_ready_o(src_ready), .src_data_i(src_data), .af_words_i(af_words),
        .ae_words_i(ae_words), .snk_valid_o(snk_valid), .snk_ready_i(snk_ready),
        .snk_data_o(snk_data), .full_o(full), .empty_o(empty), .almost_full_o(a_full),
        .almost_empty_o(a_empty), .lnk(lnk));
    fff_link_monitor #(.WR_W(4), .RD_W(2)) i_mon (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .wr_valid(lnk.wr_valid), .wr_ready(lnk.wr_ready), .rd_valid(lnk.rd_valid),
        .rd_ready(lnk.rd_ready), .rd_data(lnk.rd_data), .full(lnk.full), .empty(lnk.empty),
        .almost_full_threshold(lnk.almost_full_threshold), .almost_full_flag(lnk.almost_full_flag),
        .almost_empty_threshold(lnk.almost_empty_threshold),
        .almost_empty_flag(lnk.almost_empty_flag));
    initial
        forever #10 clk_sys_i = ~clk_sys_i;
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            fails++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic flags(input logic [3:0] e);
        chk("flags", 13'(e), 13'({full, empty, a_full, a_empty}));
    endtask
    task automatic put(input logic [3:0] d);
        int n = 0;
        @(negedge clk_sys_i);
        src_valid = 1'b1;
        src_data = d;
        #1;
        while (src_ready !== 1'b1 && n++ < 100)
            @(negedge clk_sys_i);
        chk("src_ready", 13'h1, 13'(src_ready));
        @(negedge clk_sys_i);
        src_valid = 1'b0;
    endtask
    task automatic get(input logic [1:0] e);
        int n = 0;
        @(negedge clk_sys_i);
        snk_ready = 1'b1;
        #1;
        while (snk_valid !== 1'b1 && n++ < 100)
            @(negedge clk_sys_i);
        chk("snk_valid", 13'h1, 13'(snk_valid));
        @(negedge clk_sys_i);
        snk_ready = 1'b0;
        chk("snk_data", 13'(e), 13'(snk_data));
        chk("rd_data", 13'(e), 13'(lnk.rd_data));
    endtask
    task automatic drain();
        int n = 0;
        @(negedge clk_sys_i);
        while (lnk.wr_valid !== 1'b0 && n++ < 100)
            @(negedge clk_sys_i);
        chk("wr_valid", 13'h0, 13'(lnk.wr_valid));
    endtask
    initial
    begin
        repeat (5) @(negedge clk_sys_i);
        reset_i = 1'b0;
        @(negedge clk_sys_i);
        flags(4'b0101);
        chk("af_thr", 13'd12, 13'(lnk.almost_full_threshold));
        chk("ae_thr", 13'd4, 13'(lnk.almost_empty_threshold));
        foreach (rows[i]) put(rows[i][7:4]);
        drain();
        flags(4'b0010);
        foreach (rows[i])
        begin
            get(rows[i][3:2]);
            get(rows[i][1:0]);
        end
        flags(4'b0101);
        chk("snk_valid", 13'h0, 13'(snk_valid));
        $display("Test rows done");
        put(4'h1);
        drain();
        flags(4'b0001);
        put(4'h2);
        drain();
        flags(4'b0000);
        af_words = 12'h002;
        repeat (2) @(negedge clk_sys_i);
        flags(4'b0010);
        af_words = 12'h003;
        repeat (2) @(negedge clk_sys_i);
        flags(4'b0000);
        put(4'h3);
        drain();
        flags(4'b0010);
        get(2'h1);
        flags(4'b0000);
        foreach (tail[i]) get(tail[i]);
        flags(4'b0101);
        $display("Test thresholds done");
        for (int i = 0; i < 1024; i++) put(4'(i + 5));
        drain();
        flags(4'b1010);
        repeat (8) put(4'hc);
        @(negedge clk_sys_i);
        chk("src_ready", 13'h0, 13'(src_ready));
        get(2'h1);
        flags(4'b1010);
        $display("Test fill done");
        reset_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        reset_i = 1'b0;
        @(negedge clk_sys_i);
        flags(4'b0101);
        $display("Test reset done");
        end_of_test();
    end
endmodule // fifo_flag_logic_test
